//--- core/timer_pkg.sv
// package: register map, field layout, encodings and carrier types of the compare pulse timer
package timer_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_COUNT   = 8'h00;
    localparam logic [7:0] OFS_CONST_A = 8'h04;
    localparam logic [7:0] OFS_CONST_B = 8'h08;
    localparam logic [7:0] OFS_SETUP   = 8'h0c;
    localparam logic [7:0] OFS_OUTCTL  = 8'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SETUP_CLK_LSB  = 0;
    localparam int SETUP_CLR_LSB  = 3;
    localparam int OUTCTL_ACT_LSB = 0;
    localparam int OUTCTL_OVF_BIT = 5;
    localparam int OUTCTL_MFA_BIT = 6;
    localparam int OUTCTL_MFB_BIT = 7;
    localparam int OUTCTL_LVL_BIT = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_COUNT   = 8'h00;
    localparam logic [7:0] RST_CONST   = 8'hff;
    localparam logic       RST_OUT_LVL = 1'b0;

    // ------------------------------------------------------------
    // prescaler taps (bit of free counter used as internal clock)
    // ------------------------------------------------------------
    localparam int PRESC_WIDTH = 8;
    localparam int TAP_FAST    = 2;
    localparam int TAP_SLOW    = 5;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CLK_STOP  = 2'b00,
        CLK_FAST  = 2'b01,
        CLK_SLOW  = 2'b10,
        CLK_EXT   = 2'b11
    } clk_sel_type;

    typedef enum logic [1:0] {
        CLR_NONE  = 2'b00,
        CLR_ON_A  = 2'b01,
        CLR_ON_B  = 2'b10,
        CLR_RSVD  = 2'b11
    } clr_sel_type;

    typedef enum logic [1:0] {
        ACT_NONE   = 2'b00,
        ACT_LOW    = 2'b01,
        ACT_HIGH   = 2'b10,
        ACT_TOGGLE = 2'b11
    } out_action_type;

    // ------------------------------------------------------------
    // carrier: the timer configuration as software set it
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] count_clear_sel;       // hi, lo
        logic [1:0] clock_source_sel;      // hi, lo
        logic [1:0] act_b;                 // output_action_select[3:2]
        logic [1:0] act_a;                 // output_action_select[1:0]
    } timer_cfg_type;

endpackage : timer_pkg

//--- core/count_tick_gen.sv
// module: clock source selection and falling edge detector producing count ticks
`timescale 1ns/100ps
module count_tick_gen #(
    parameter int PRESC_W  = timer_pkg::PRESC_WIDTH,
    parameter int TAP_F    = timer_pkg::TAP_FAST,
    parameter int TAP_S    = timer_pkg::TAP_SLOW
) (
    input  wire logic       clk_in,        // system clock
    input  wire logic       rst_in,        // async reset, high
    input  wire logic [1:0] clk_sel_in,    // clock source select
    input  wire logic       ext_clk_in,    // external clock pin
    output logic            tick_out       // one-cycle count pulse
);

    // taps outside the prescaler cannot be served: refuse at elaboration
    if (TAP_F >= PRESC_W || TAP_S >= PRESC_W || TAP_F < 0 || TAP_S < 0) begin : g_bad_taps
        $error("prescaler taps exceed prescaler width");
    end

    logic [PRESC_W-1:0] presc_r;
    logic               ext_sync1_r;
    logic               ext_sync2_r;
    logic               sel_lvl_r;
    logic               sel_lvl_nxt;
    logic               tick_r;

    // ------------------------------------------------------------
    // prescaler and pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            presc_r <= '0;
        end else begin
            presc_r <= presc_r + {{(PRESC_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ext_sync1_r <= 1'b1;
            ext_sync2_r <= 1'b1;
        end else begin
            ext_sync1_r <= ext_clk_in;
            ext_sync2_r <= ext_sync1_r;
        end
    end

    // ------------------------------------------------------------
    // selected level and falling edge
    // ------------------------------------------------------------
    // a switch of source that lands low after high is seen as an edge
    always_comb begin
        case (clk_sel_in)
            timer_pkg::CLK_FAST: sel_lvl_nxt = presc_r[TAP_F];
            timer_pkg::CLK_SLOW: sel_lvl_nxt = presc_r[TAP_S];
            timer_pkg::CLK_EXT:  sel_lvl_nxt = ext_sync2_r;
            default:             sel_lvl_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_lvl_r <= 1'b1;
            tick_r    <= 1'b0;
        end else begin
            sel_lvl_r <= sel_lvl_nxt;
            tick_r    <= sel_lvl_r & ~sel_lvl_nxt;
        end
    end

    assign tick_out = tick_r;

    AST_FALL_TICKS: assert property (@(posedge clk_in) disable iff (rst_in)
        (sel_lvl_r && !sel_lvl_nxt) |=> tick_out)
        else $error("falling selected level gave no tick");

    AST_NO_EDGE_NO_TICK: assert property (@(posedge clk_in) disable iff (rst_in)
        !(sel_lvl_r && !sel_lvl_nxt) |=> !tick_out)
        else $error("tick without falling edge");

    AST_EXT_FALL: assert property (@(posedge clk_in) disable iff (rst_in)
        (clk_sel_in == timer_pkg::CLK_EXT && $past(clk_sel_in) == timer_pkg::CLK_EXT
         && sel_lvl_r && !ext_sync2_r) |=> tick_out)
        else $error("external falling edge missed");

endmodule : count_tick_gen

//--- core/eight_bit_compare_pulse_timer.sv
// module: 8-bit up counter with two compare constants, pulse output pin and apb registers
// How it works
// - clear select 01 resets the counter to zero on each match with constant a.
// - action pattern 0110 drives output high on match a, low on match b.
// - simultaneous matches settle output by fixed priority: toggle, then high, then low.
// - internal clock counting uses falling edges of the selected prescaled clock.
// - a select rewrite taking the sampled clock high to low counts once.
// - switching between internal and external clock may also count spuriously.
`timescale 1ns/100ps
module eight_bit_compare_pulse_timer (
    input  wire logic        clk_in,       // 125 MHz system clock
    input  wire logic        rst_in,       // async reset, high
    input  wire logic        psel_in,      // apb select
    input  wire logic        penable_in,   // apb enable
    input  wire logic        pwrite_in,    // apb direction
    input  wire logic [7:0]  paddr_in,     // apb byte address
    input  wire logic [31:0] pwdata_in,    // apb write data
    output logic [31:0]      prdata_out,   // apb read data
    output logic             pready_out,   // apb ready
    output logic             pslverr_out,  // apb error, unmapped address
    input  wire logic        ext_clk_in,   // external count clock pin
    output logic             timer_pin_out // pulse output pin
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == timer_pkg::OFS_COUNT) || (a == timer_pkg::OFS_CONST_A) ||
                      (a == timer_pkg::OFS_CONST_B) || (a == timer_pkg::OFS_SETUP) ||
                      (a == timer_pkg::OFS_OUTCTL);
    endfunction : addr_mapped

    function automatic logic [1:0] act_rank(input logic [1:0] act);
        case (act)
            timer_pkg::ACT_TOGGLE: act_rank = 2'h3;
            timer_pkg::ACT_HIGH:   act_rank = 2'h2;
            timer_pkg::ACT_LOW:    act_rank = 2'h1;
            default:               act_rank = 2'h0;
        endcase
    endfunction : act_rank

    function automatic logic act_apply(input logic [1:0] act, input logic cur);
        case (act)
            timer_pkg::ACT_TOGGLE: act_apply = ~cur;
            timer_pkg::ACT_HIGH:   act_apply = 1'b1;
            timer_pkg::ACT_LOW:    act_apply = 1'b0;
            default:               act_apply = cur;
        endcase
    endfunction : act_apply

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]               timer_count_value_r;
    logic [7:0]               match_constant_a_r;
    logic [7:0]               match_constant_b_r;
    timer_pkg::timer_cfg_type cfg_r;
    logic                     flag_a_r;
    logic                     flag_b_r;
    logic                     flag_ovf_r;
    logic                     pin_r;
    logic                     pin_nxt;
    logic [31:0]              prdata_r;
    logic                     pready_r;
    logic                     pslverr_r;

    logic                     tick;
    logic                     setup_ph;
    logic                     wr_go;
    logic                     eq_a;
    logic                     eq_b;
    logic                     ev_a;
    logic                     ev_b;
    logic                     clear_hit;
    logic                     wr_count;
    logic                     wr_outctl;
    logic [1:0]               act_win;

    // ------------------------------------------------------------
    // count tick source
    // ------------------------------------------------------------
    count_tick_gen #(
        .PRESC_W    (timer_pkg::PRESC_WIDTH),
        .TAP_F      (timer_pkg::TAP_FAST),
        .TAP_S      (timer_pkg::TAP_SLOW)
    ) u_tick (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .clk_sel_in (cfg_r.clock_source_sel),
        .ext_clk_in (ext_clk_in),
        .tick_out   (tick)
    );

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    assign setup_ph  = psel_in & ~penable_in;
    assign wr_go     = psel_in & penable_in & pready_r & pwrite_in & ~pslverr_r;
    assign wr_count  = wr_go && (paddr_in == timer_pkg::OFS_COUNT);
    assign wr_outctl = wr_go && (paddr_in == timer_pkg::OFS_OUTCTL);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup_ph;
            pslverr_r <= setup_ph & ~addr_mapped(paddr_in);
            if (setup_ph && !pwrite_in) begin
                case (paddr_in)
                    timer_pkg::OFS_COUNT:   prdata_r <= {24'h00_0000, timer_count_value_r};
                    timer_pkg::OFS_CONST_A: prdata_r <= {24'h00_0000, match_constant_a_r};
                    timer_pkg::OFS_CONST_B: prdata_r <= {24'h00_0000, match_constant_b_r};
                    timer_pkg::OFS_SETUP:   prdata_r <= {27'h000_0000, cfg_r.count_clear_sel,
                                                         1'b0, cfg_r.clock_source_sel};
                    timer_pkg::OFS_OUTCTL:  prdata_r <= {23'h00_0000, pin_r, flag_b_r, flag_a_r,
                                                         flag_ovf_r, 1'b0, cfg_r.act_b, cfg_r.act_a};
                    default:                prdata_r <= 32'h0000_0000;
                endcase
            end else if (setup_ph) begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    assign prdata_out  = prdata_r;
    assign pready_out  = pready_r;
    assign pslverr_out = pslverr_r;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            match_constant_a_r <= timer_pkg::RST_CONST;
            match_constant_b_r <= timer_pkg::RST_CONST;
            cfg_r              <= '0;
        end else if (wr_go) begin
            case (paddr_in)
                timer_pkg::OFS_CONST_A: match_constant_a_r <= pwdata_in[7:0];
                timer_pkg::OFS_CONST_B: match_constant_b_r <= pwdata_in[7:0];
                timer_pkg::OFS_SETUP: begin
                    cfg_r.clock_source_sel <= pwdata_in[timer_pkg::SETUP_CLK_LSB +: 2];
                    cfg_r.count_clear_sel  <= pwdata_in[timer_pkg::SETUP_CLR_LSB +: 2];
                end
                timer_pkg::OFS_OUTCTL: begin
                    cfg_r.act_a <= pwdata_in[timer_pkg::OUTCTL_ACT_LSB +: 2];
                    cfg_r.act_b <= pwdata_in[timer_pkg::OUTCTL_ACT_LSB + 2 +: 2];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // counter and compare
    // ------------------------------------------------------------
    assign eq_a      = (timer_count_value_r == match_constant_a_r);
    assign eq_b      = (timer_count_value_r == match_constant_b_r);
    assign ev_a      = tick & eq_a;
    assign ev_b      = tick & eq_b;
    assign clear_hit = (cfg_r.count_clear_sel == timer_pkg::CLR_ON_A && ev_a) ||
                       (cfg_r.count_clear_sel == timer_pkg::CLR_ON_B && ev_b);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            timer_count_value_r <= timer_pkg::RST_COUNT;
        end else if (wr_count) begin
            timer_count_value_r <= pwdata_in[7:0];
        end else if (clear_hit) begin
            timer_count_value_r <= 8'h00;
        end else if (tick) begin
            timer_count_value_r <= timer_count_value_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // status flags: an event in the clearing cycle wins
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            flag_a_r   <= 1'b0;
            flag_b_r   <= 1'b0;
            flag_ovf_r <= 1'b0;
        end else begin
            flag_a_r   <= ev_a | (flag_a_r & ~(wr_outctl & ~pwdata_in[timer_pkg::OUTCTL_MFA_BIT]));
            flag_b_r   <= ev_b | (flag_b_r & ~(wr_outctl & ~pwdata_in[timer_pkg::OUTCTL_MFB_BIT]));
            flag_ovf_r <= (tick & ~clear_hit & ~wr_count & (&timer_count_value_r)) |
                          (flag_ovf_r & ~(wr_outctl & ~pwdata_in[timer_pkg::OUTCTL_OVF_BIT]));
        end
    end

    // ------------------------------------------------------------
    // output pin
    // ------------------------------------------------------------
    always_comb begin
        act_win = timer_pkg::ACT_NONE;
        pin_nxt = pin_r;
        if (ev_a && ev_b) begin
            act_win = (act_rank(cfg_r.act_a) >= act_rank(cfg_r.act_b)) ? cfg_r.act_a : cfg_r.act_b;
            pin_nxt = act_apply(act_win, pin_r);
        end else if (ev_a) begin
            pin_nxt = act_apply(cfg_r.act_a, pin_r);
        end else if (ev_b) begin
            pin_nxt = act_apply(cfg_r.act_b, pin_r);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_r <= timer_pkg::RST_OUT_LVL;
        end else begin
            pin_r <= pin_nxt;
        end
    end

    assign timer_pin_out = pin_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_CLEAR_ON_A: assert property (@(posedge clk_in) disable iff (rst_in)
        (tick && eq_a && !wr_count && cfg_r.count_clear_sel == 2'b01) |=> timer_count_value_r == 8'h00)
        else $error("counter not cleared on match a");

    AST_HIGH_ON_A: assert property (@(posedge clk_in) disable iff (rst_in)
        (ev_a && !ev_b && cfg_r.act_a == 2'b10) |=> timer_pin_out)
        else $error("output not high after match a");

    AST_LOW_ON_B: assert property (@(posedge clk_in) disable iff (rst_in)
        (ev_b && !ev_a && cfg_r.act_b == 2'b01) |=> !timer_pin_out)
        else $error("output not low after match b");

    AST_BOTH_TOGGLE: assert property (@(posedge clk_in) disable iff (rst_in)
        (ev_a && ev_b && (cfg_r.act_a == 2'b11 || cfg_r.act_b == 2'b11))
        |=> timer_pin_out != $past(timer_pin_out))
        else $error("toggle lost priority on double match");

    AST_BOTH_HIGH_OVER_LOW: assert property (@(posedge clk_in) disable iff (rst_in)
        (ev_a && ev_b && cfg_r.act_a == 2'b10 && cfg_r.act_b == 2'b01) |=> timer_pin_out)
        else $error("high lost priority over low");

    AST_INCREMENT: assert property (@(posedge clk_in) disable iff (rst_in)
        (tick && !clear_hit && !wr_count) |=> timer_count_value_r == $past(timer_count_value_r) + 8'h01)
        else $error("counter did not step on tick");

    AST_IDLE_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
        (!tick && !wr_count) |=> $stable(timer_count_value_r))
        else $error("counter moved without tick");

    AST_PIN_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
        !(ev_a || ev_b) |=> $stable(timer_pin_out))
        else $error("output moved between matches");

    AST_FLAG_SET_WINS: assert property (@(posedge clk_in) disable iff (rst_in)
        ev_a |=> flag_a_r)
        else $error("match a flag lost");

    AST_APB_ANSWER: assert property (@(posedge clk_in) disable iff (rst_in)
        (psel_in && !penable_in) |=> pready_out)
        else $error("apb access not answered in first access cycle");

endmodule : eight_bit_compare_pulse_timer

//--- dv/ext_clk_model.sv
// partner model: external count clock source feeding the timer's clock pin
`timescale 1ns/100ps
module ext_clk_model (
    input  wire logic clk_in,     // system clock, pacing only
    output logic      ext_clk_out // external count clock pin
);
    // ------------------------------------------------------------
    // pin idles high; outside a burst it moves only through set_level
    // ------------------------------------------------------------
    initial ext_clk_out = 1'b1;

    task automatic set_level(input logic lvl);
        @(posedge clk_in);
        ext_clk_out <= lvl;
    endtask : set_level

    // each phase lasts 4 system cycles so the synchroniser sees every level
    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge clk_in);
            ext_clk_out <= 1'b0;
            repeat (4) @(posedge clk_in);
            ext_clk_out <= 1'b1;
        end
    endtask : burst
endmodule : ext_clk_model

//--- dv/eight_bit_compare_pulse_timer_bench.sv
// testbench: apb register access, pulse generation, match priority and clock switching
`timescale 1ns/100ps
module eight_bit_compare_pulse_timer_bench;
    logic        clk_in, rst_in, psel_in, penable_in, pwrite_in;
    logic        ext_clk_in, pready_out, pslverr_out, timer_pin_out;
    logic [7:0]  paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic        err;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cyc = 0;

    // ------------------------------------------------------------
    // clock, design and partner
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    eight_bit_compare_pulse_timer dut_u (
        .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .ext_clk_in(ext_clk_in),
        .timer_pin_out(timer_pin_out)
    );

    ext_clk_model ext_u (.clk_in(clk_in), .ext_clk_out(ext_clk_in));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge clk_in);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= wr;
        paddr_in   <= addr;
        pwdata_in  <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rd  = prdata_out;
        err = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        apb(1'b1, addr, wd);
    endtask : wr

    task automatic rdc(input string what, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(what, rd, exp);
    endtask : rdc

    // cycles the pin stays at lvl, sampled at each rising edge
    task automatic meas(input logic lvl, output int n);
        n = 0;
        while (timer_pin_out === lvl) begin
            @(posedge clk_in);
            n++;
        end
    endtask : meas

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdc("count", timer_pkg::OFS_COUNT, 32'h0);
        rdc("const a", timer_pkg::OFS_CONST_A, 32'hff);
        rdc("const b", timer_pkg::OFS_CONST_B, 32'hff);
        rdc("setup", timer_pkg::OFS_SETUP, 32'h0);
        rdc("outctl", timer_pkg::OFS_OUTCTL, 32'h0);
        rdc("unmapped data", 8'h14, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        $display("reset and map test done");
    endtask : t_reset

    // period 10 ticks of 8 cycles, high from match a to match b (4 ticks)
    task automatic t_pulse();
        int hi;
        int lo;
        wr(timer_pkg::OFS_CONST_A, 32'h9);
        wr(timer_pkg::OFS_CONST_B, 32'h3);
        wr(timer_pkg::OFS_OUTCTL, 32'h6);
        wr(timer_pkg::OFS_SETUP, 32'h9);
        while (timer_pin_out !== 1'b1) @(posedge clk_in);
        meas(1'b1, hi);
        chk("high width", hi, 32'd32);
        meas(1'b0, lo);
        chk("low width", lo, 32'd48);
        meas(1'b1, hi);
        chk("high width again", hi, 32'd32);
        rdc("match flags", timer_pkg::OFS_OUTCTL, 32'h0c6);
        $display("pulse output test done");
    endtask : t_pulse

    // a equals b: both matches fall on one tick, priority decides the pin
    task automatic t_prio();
        logic [31:0] acts [4] = '{32'h6, 32'h7, 32'h9, 32'h4};
        int          exp_hi [4] = '{192, 96, 192, 0};
        int          hi;
        wr(timer_pkg::OFS_CONST_A, 32'h5);
        wr(timer_pkg::OFS_CONST_B, 32'h5);
        for (int i = 0; i < 4; i++) begin
            wr(timer_pkg::OFS_OUTCTL, acts[i]);
            repeat (64) @(posedge clk_in);
            hi = 0;
            repeat (192) begin
                @(posedge clk_in);
                hi += (timer_pin_out === 1'b1) ? 1 : 0;
            end
            chk("priority high cycles", hi, exp_hi[i]);
        end
        $display("priority test done");
    endtask : t_prio

    // stopped select reads high; selecting a low external pin counts once
    task automatic t_switch();
        wr(timer_pkg::OFS_SETUP, 32'h0);
        wr(timer_pkg::OFS_OUTCTL, 32'h0);
        ext_u.set_level(1'b0);
        wr(timer_pkg::OFS_COUNT, 32'h0);
        wr(timer_pkg::OFS_SETUP, 32'h3);
        repeat (8) @(posedge clk_in);
        rdc("count after select", timer_pkg::OFS_COUNT, 32'h1);
        ext_u.set_level(1'b1);
        ext_u.burst(5);
        repeat (8) @(posedge clk_in);
        rdc("count after burst", timer_pkg::OFS_COUNT, 32'h6);
        wr(timer_pkg::OFS_SETUP, 32'h0);
        repeat (8) @(posedge clk_in);
        rdc("count after stop", timer_pkg::OFS_COUNT, 32'h6);
        $display("clock switch test done");
    endtask : t_switch

    // slow tap with clear on b: toggle every 3 ticks of 64 cycles; then overflow from ff
    task automatic t_slow();
        int hi;
        int lo;
        wr(timer_pkg::OFS_CONST_B, 32'h2);
        wr(timer_pkg::OFS_COUNT, 32'h0);
        wr(timer_pkg::OFS_OUTCTL, 32'hc);
        wr(timer_pkg::OFS_SETUP, 32'h12);
        while (timer_pin_out !== 1'b1) @(posedge clk_in);
        meas(1'b1, hi);
        chk("slow high width", hi, 32'd192);
        meas(1'b0, lo);
        chk("slow low width", lo, 32'd192);
        wr(timer_pkg::OFS_SETUP, 32'h0);
        wr(timer_pkg::OFS_OUTCTL, 32'h0);
        wr(timer_pkg::OFS_CONST_A, 32'h80);
        wr(timer_pkg::OFS_CONST_B, 32'h80);
        wr(timer_pkg::OFS_COUNT, 32'hff);
        wr(timer_pkg::OFS_SETUP, 32'h1);
        repeat (16) @(posedge clk_in);
        rdc("overflow flag and held pin", timer_pkg::OFS_OUTCTL, 32'h120);
        $display("slow clock and overflow test done");
    endtask : t_slow

    // ------------------------------------------------------------
    // timeout and main sequence
    // ------------------------------------------------------------
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        rst_in     = 1'b1;
        psel_in    = 1'b0;
        penable_in = 1'b0;
        pwrite_in  = 1'b0;
        paddr_in   = 8'h00;
        pwdata_in  = 32'h0;
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_pulse();
        t_prio();
        t_switch();
        t_slow();
        close_out();
    end
endmodule : eight_bit_compare_pulse_timer_bench
